// >>> irq_handler_consts.vh
// constants for the two level interrupt handler
// assumes one 100 MHz clock and an 8-bit register port
`ifndef IRQ_HANDLER_CONSTS_VH
`define IRQ_HANDLER_CONSTS_VH

// ***************************************************
// register addresses
// ***************************************************
`define ADDR_IE 8'hA8
`define ADDR_EIE1 8'hE6
`define ADDR_EIE2 8'hE7
`define ADDR_IP 8'hB8
`define ADDR_EIP1 8'hF6
`define ADDR_EIP2 8'hF7
`define ADDR_PEND0 8'h70
`define ADDR_PEND1 8'h71
`define ADDR_PEND2 8'h72
`define ADDR_EVT_STAT 8'h74
`define ADDR_EVT_MASK 8'h75
`define ADDR_NEST 8'h76

// ***************************************************
// field layout and reset values
// ***************************************************
`define GATE_BIT 7
`define SRC_PAD 23
`define BYTE0_LO 0
`define BYTE1_LO 7
`define BYTE2_LO 15
`define RST_BYTE 8'h00
`define RST_SRC 23'h00_0000
`define RST_EVT 3'h0
`define EVT_W 3
`define EVT_CALL 0
`define EVT_PREEMPT 1
`define EVT_RETURN 2

// ***************************************************
// timing
// ***************************************************
`define CLK_PERIOD_NS 10
`define MIN_RESPONSE_CYC 7
`define DETECT_CYC 1

`endif

// >>> two_level_interrupt_handler.v
// two level interrupt handler: pending flags, enables, priorities,
// arbitration, vector call requests and nesting state
// assumes the core pulses inst_done at each instruction boundary and
// return_from_interrupt_done together with it when that instruction was the return
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "irq_handler_consts.vh"

module two_level_interrupt_handler #(
	parameter N_SRC = 19,
	parameter VEC_W = 16,
	parameter [N_SRC-1:0] HW_CLEAR = 19'h0_000F,
	parameter [N_SRC*VEC_W-1:0] VEC_TABLE = {
		16'h0093, 16'h008B, 16'h0083, 16'h007B, 16'h0073, 16'h006B, 16'h0063,
		16'h005B, 16'h0053, 16'h004B, 16'h0043, 16'h003B, 16'h0033, 16'h002B,
		16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003}
) (
	input wire clk_sys,
	input wire reset_n,
	input wire [N_SRC-1:0] src_event,
	input wire inst_done,
	input wire return_from_interrupt_done,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_ff,
	output reg call_req_ff,
	output reg [VEC_W-1:0] call_vector_ff,
	output reg [4:0] call_src_ff,
	output reg in_service_hi_ff,
	output reg in_service_lo_ff,
	output reg irq_ff
);

	// ***************************************************
	// helper functions
	// ***************************************************

	// byte-wide merge of a padded source vector from three registers
	function [`SRC_PAD-1:0] merge_src;
		input [`SRC_PAD-1:0] old;
		input [7:0] addr;
		input [7:0] data;
		input [7:0] a0;
		input [7:0] a1;
		input [7:0] a2;
		reg [`SRC_PAD-1:0] v;
		begin
			v = old;
			if (addr == a0) begin
				v[`BYTE1_LO-1:`BYTE0_LO] = data[6:0];
			end else if (addr == a1) begin
				v[`BYTE2_LO-1:`BYTE1_LO] = data;
			end else if (addr == a2) begin
				v[`SRC_PAD-1:`BYTE2_LO] = data;
			end
			merge_src = v;
		end
	endfunction

	// fixed order: lowest source number wins a tie
	function [5:0] first_set;
		input [`SRC_PAD-1:0] v;
		integer i;
		begin
			first_set = 6'h00;
			for (i = `SRC_PAD - 1; i >= 0; i = i - 1) begin
				if (v[i]) begin
					first_set = {1'b1, i[4:0]};
				end
			end
		end
	endfunction

	// ***************************************************
	// state
	// ***************************************************
	reg gate_ff;
	reg [`SRC_PAD-1:0] en_ff;
	reg [`SRC_PAD-1:0] prio_ff;
	reg [`SRC_PAD-1:0] pend_ff;
	reg [`EVT_W-1:0] evt_stat_ff;
	reg [`EVT_W-1:0] evt_mask_ff;
	reg win_valid_ff;
	reg win_hi_ff;
	reg [4:0] win_src_ff;

	reg [`SRC_PAD-1:0] nxt_pend;
	reg [`SRC_PAD-1:0] pend_clr;
	reg [`SRC_PAD-1:0] ev_pad;
	reg [`SRC_PAD-1:0] hw_clr_pad;
	reg [`EVT_W-1:0] evt_set;
	reg [`EVT_W-1:0] nxt_evt_stat;

	wire [`SRC_PAD-1:0] req_all;
	wire [`SRC_PAD-1:0] req_hi;
	wire [`SRC_PAD-1:0] req_lo;
	wire [5:0] pick_hi;
	wire [5:0] pick_lo;
	wire allow_hi;
	wire allow_lo;
	wire take_call;
	wire wr_evt;

	// ***************************************************
	// request qualification and arbitration
	// ***************************************************

	// a pending flag only reaches arbitration when enabled and gated
	assign req_all = pend_ff & en_ff & {`SRC_PAD{gate_ff}};
	assign req_hi = req_all & prio_ff;
	assign req_lo = req_all & ~prio_ff;
	assign pick_hi = first_set(req_hi);
	assign pick_lo = first_set(req_lo);

	// a running high level blocks everything, a running low blocks low
	assign allow_hi = !in_service_hi_ff;
	assign allow_lo = !in_service_hi_ff && !in_service_lo_ff;

	// winner registered each cycle: one cycle of detection latency
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			win_valid_ff <= 1'b0;
			win_hi_ff <= 1'b0;
			win_src_ff <= 5'h00;
		end else if (allow_hi && pick_hi[5]) begin
			win_valid_ff <= 1'b1;
			win_hi_ff <= 1'b1;
			win_src_ff <= pick_hi[4:0];
		end else if (allow_lo && pick_lo[5]) begin
			win_valid_ff <= 1'b1;
			win_hi_ff <= 1'b0;
			win_src_ff <= pick_lo[4:0];
		end else begin
			win_valid_ff <= 1'b0;
			win_hi_ff <= 1'b0;
			win_src_ff <= 5'h00;
		end
	end

	// ***************************************************
	// vector call
	// ***************************************************

	// the return boundary itself never vectors, so at least one
	// instruction runs between a return and the next call; the cycle
	// right after a call is skipped because the winner is stale then
	assign take_call = inst_done && !return_from_interrupt_done && win_valid_ff
		&& !call_req_ff;

	// call pulse with the vector looked up from the table
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			call_req_ff <= 1'b0;
			call_vector_ff <= {VEC_W{1'b0}};
			call_src_ff <= 5'h00;
		end else begin
			call_req_ff <= take_call;
			if (take_call) begin
				call_vector_ff <= VEC_TABLE[win_src_ff*VEC_W +: VEC_W];
				call_src_ff <= win_src_ff;
			end
		end
	end

	// ***************************************************
	// nesting levels
	// ***************************************************

	// a return closes the innermost level, so a preempted low
	// routine carries on after the high one returns
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			in_service_hi_ff <= 1'b0;
			in_service_lo_ff <= 1'b0;
		end else if (take_call) begin
			if (win_hi_ff) begin
				in_service_hi_ff <= 1'b1;
			end else begin
				in_service_lo_ff <= 1'b1;
			end
		end else if (return_from_interrupt_done) begin
			if (in_service_hi_ff) begin
				in_service_hi_ff <= 1'b0;
			end else begin
				in_service_lo_ff <= 1'b0;
			end
		end
	end

	// ***************************************************
	// pending flags
	// ***************************************************

	// software write replaces a byte; vectoring clears some flags;
	// a hardware event in the same cycle wins over either clear
	always @* begin
		ev_pad = `RST_SRC;
		ev_pad[N_SRC-1:0] = src_event;
		hw_clr_pad = `RST_SRC;
		hw_clr_pad[N_SRC-1:0] = HW_CLEAR;
		pend_clr = `RST_SRC;
		if (take_call) begin
			pend_clr[win_src_ff] = hw_clr_pad[win_src_ff];
		end
		nxt_pend = pend_ff & ~pend_clr;
		if (reg_wr) begin
			nxt_pend = merge_src(nxt_pend, reg_addr, reg_wdata,
				`ADDR_PEND0, `ADDR_PEND1, `ADDR_PEND2);
		end
		nxt_pend = (nxt_pend | ev_pad) & ~(~`RST_SRC << N_SRC);
	end

	// flags keep their value while gated off, so nothing is lost
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			pend_ff <= `RST_SRC;
		end else begin
			pend_ff <= nxt_pend;
		end
	end

	// ***************************************************
	// enable and priority registers
	// ***************************************************

	// bits above the implemented sources are held at zero
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			gate_ff <= 1'b0;
			en_ff <= `RST_SRC;
			prio_ff <= `RST_SRC;
		end else if (reg_wr) begin
			if (reg_addr == `ADDR_IE) begin
				gate_ff <= reg_wdata[`GATE_BIT];
			end
			en_ff <= merge_src(en_ff, reg_addr, reg_wdata,
				`ADDR_IE, `ADDR_EIE1, `ADDR_EIE2)
				& ~(~`RST_SRC << N_SRC);
			prio_ff <= merge_src(prio_ff, reg_addr, reg_wdata,
				`ADDR_IP, `ADDR_EIP1, `ADDR_EIP2)
				& ~(~`RST_SRC << N_SRC);
		end
	end

	// ***************************************************
	// event status, mask and interrupt line
	// ***************************************************
	assign wr_evt = reg_wr && (reg_addr == `ADDR_EVT_STAT);

	// sticky events, write one to clear, a new event wins the clear
	always @* begin
		evt_set = `RST_EVT;
		evt_set[`EVT_CALL] = take_call;
		evt_set[`EVT_PREEMPT] = take_call && win_hi_ff && in_service_lo_ff;
		evt_set[`EVT_RETURN] = return_from_interrupt_done;
		nxt_evt_stat = evt_stat_ff;
		if (wr_evt) begin
			nxt_evt_stat = evt_stat_ff & ~reg_wdata[`EVT_W-1:0];
		end
		nxt_evt_stat = nxt_evt_stat | evt_set;
	end

	// the line follows the stored bits, one cycle behind them
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			evt_stat_ff <= `RST_EVT;
			evt_mask_ff <= `RST_EVT;
			irq_ff <= 1'b0;
		end else begin
			evt_stat_ff <= nxt_evt_stat;
			if (reg_wr && (reg_addr == `ADDR_EVT_MASK)) begin
				evt_mask_ff <= reg_wdata[`EVT_W-1:0];
			end
			irq_ff <= |(evt_stat_ff & evt_mask_ff);
		end
	end

	// ***************************************************
	// register read port
	// ***************************************************

	// data stand for the single cycle after the strobe, else zero;
	// unmapped addresses read zero
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			reg_rdata_ff <= `RST_BYTE;
		end else if (!reg_rd) begin
			reg_rdata_ff <= `RST_BYTE;
		end else if (reg_addr == `ADDR_IE) begin
			reg_rdata_ff <= {gate_ff, en_ff[`BYTE1_LO-1:`BYTE0_LO]};
		end else if (reg_addr == `ADDR_EIE1) begin
			reg_rdata_ff <= en_ff[`BYTE2_LO-1:`BYTE1_LO];
		end else if (reg_addr == `ADDR_EIE2) begin
			reg_rdata_ff <= en_ff[`SRC_PAD-1:`BYTE2_LO];
		end else if (reg_addr == `ADDR_IP) begin
			reg_rdata_ff <= {1'b0, prio_ff[`BYTE1_LO-1:`BYTE0_LO]};
		end else if (reg_addr == `ADDR_EIP1) begin
			reg_rdata_ff <= prio_ff[`BYTE2_LO-1:`BYTE1_LO];
		end else if (reg_addr == `ADDR_EIP2) begin
			reg_rdata_ff <= prio_ff[`SRC_PAD-1:`BYTE2_LO];
		end else if (reg_addr == `ADDR_PEND0) begin
			reg_rdata_ff <= {1'b0, pend_ff[`BYTE1_LO-1:`BYTE0_LO]};
		end else if (reg_addr == `ADDR_PEND1) begin
			reg_rdata_ff <= pend_ff[`BYTE2_LO-1:`BYTE1_LO];
		end else if (reg_addr == `ADDR_PEND2) begin
			reg_rdata_ff <= pend_ff[`SRC_PAD-1:`BYTE2_LO];
		end else if (reg_addr == `ADDR_EVT_STAT) begin
			reg_rdata_ff <= {5'h00, evt_stat_ff};
		end else if (reg_addr == `ADDR_EVT_MASK) begin
			reg_rdata_ff <= {5'h00, evt_mask_ff};
		end else if (reg_addr == `ADDR_NEST) begin
			reg_rdata_ff <= {6'h00, in_service_hi_ff, in_service_lo_ff};
		end else begin
			reg_rdata_ff <= `RST_BYTE;
		end
	end

endmodule

// >>> irq_core_model.sv
// core model: paces instruction boundaries, issues returns on request
// assumes the bench pulses ret_go for one cycle to ask for a return
`timescale 1ns/1ps
module irq_core_model (
	input wire clk_sys,
	input wire reset_n,
	input wire [2:0] gap,
	input wire ret_go,
	output reg inst_done,
	output reg return_from_interrupt_done
);
	reg [2:0] cnt_ff;
	reg ret_pend_ff;
	wire edge_now = (cnt_ff == gap);
	// *********
	// pacing
	// *********
	// a return only ends at a boundary, so a long gap models a slow core
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			cnt_ff <= 3'h0;
			ret_pend_ff <= 1'b0;
			inst_done <= 1'b0;
			return_from_interrupt_done <= 1'b0;
		end else begin
			cnt_ff <= edge_now ? 3'h0 : cnt_ff + 3'h1;
			inst_done <= edge_now;
			return_from_interrupt_done <= edge_now && ret_pend_ff;
			ret_pend_ff <= ret_go | (ret_pend_ff & ~edge_now);
		end
	end
endmodule

// >>> two_level_interrupt_handler_checker.sv
// assertions on the handler's core-side ports
// assumes the default vector table, 0x0003 plus 8 per source
`timescale 1ns/1ps
module irq_checker #(
	parameter VEC_W = 16
) (
	input wire clk_sys,
	input wire reset_n,
	input wire inst_done,
	input wire return_from_interrupt_done,
	input wire call_req_ff,
	input wire [VEC_W-1:0] call_vector_ff,
	input wire [4:0] call_src_ff,
	input wire in_service_hi_ff,
	input wire in_service_lo_ff
);
	// *********
	// properties
	// *********
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	// a call and the two kinds of return
	sequence call_s;
		call_req_ff;
	endsequence
	sequence ret_hi_s;
		return_from_interrupt_done && in_service_hi_ff;
	endsequence
	sequence ret_lo_s;
		return_from_interrupt_done && !in_service_hi_ff;
	endsequence
	call_pulse_a: assert property (call_s |=> !call_req_ff)
		else $error("call longer than one cycle");
	call_cause_a: assert property (call_s |-> $past(inst_done && !return_from_interrupt_done))
		else $error("call without a plain boundary");
	call_vector_a: assert property (call_s |-> call_vector_ff == 16'h0003 + 16'h0008 * call_src_ff)
		else $error("wrong vector");
	vector_hold_a: assert property (!call_req_ff |-> $stable(call_vector_ff) && $stable(call_src_ff))
		else $error("vector moved between calls");
	call_level_a: assert property (call_s |-> in_service_hi_ff || in_service_lo_ff)
		else $error("call opened no level");
	hi_block_a: assert property (in_service_hi_ff |=> !call_req_ff)
		else $error("high routine preempted");
	ret_hi_a: assert property (ret_hi_s |=> !in_service_hi_ff && in_service_lo_ff == $past(in_service_lo_ff))
		else $error("high return mishandled");
	ret_lo_a: assert property (ret_lo_s |=> !in_service_lo_ff)
		else $error("low return left level open");
	return_from_interrupt_wait_a: assert property (return_from_interrupt_done |=> !call_req_ff)
		else $error("call on the return itself");
endmodule
bind two_level_interrupt_handler irq_checker #(.VEC_W(VEC_W)) u_chk (
	.clk_sys(clk_sys), .reset_n(reset_n), .inst_done(inst_done), .return_from_interrupt_done(return_from_interrupt_done),
	.call_req_ff(call_req_ff), .call_vector_ff(call_vector_ff), .call_src_ff(call_src_ff),
	.in_service_hi_ff(in_service_hi_ff), .in_service_lo_ff(in_service_lo_ff)
);

// >>> tb_two_level_interrupt_handler.sv
// bench for the two level interrupt handler
// assumes default parameters: 19 sources, sources 0..3 cleared on call
`timescale 1ns/1ps
`include "irq_handler_consts.vh"
module tb_two_level_interrupt_handler;
	reg clk_sys = 1'b0;
	reg reset_n = 1'b0;
	reg [18:0] src_event = 19'h0_0000;
	reg [7:0] reg_addr = 8'h00;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg [2:0] gap = 3'h3;
	reg ret_go = 1'b0;
	wire [7:0] reg_rdata_ff;
	wire [15:0] call_vector_ff;
	wire [4:0] call_src_ff;
	wire inst_done, return_from_interrupt_done, call_req_ff, in_service_hi_ff, in_service_lo_ff, irq_ff;
	integer n_errors = 0;
	integer compares = 0;
	two_level_interrupt_handler dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.src_event(src_event), .inst_done(inst_done), .return_from_interrupt_done(return_from_interrupt_done),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_ff(reg_rdata_ff), .call_req_ff(call_req_ff), .call_vector_ff(call_vector_ff),
		.call_src_ff(call_src_ff), .in_service_hi_ff(in_service_hi_ff),
		.in_service_lo_ff(in_service_lo_ff), .irq_ff(irq_ff));
	irq_core_model core (.clk_sys(clk_sys), .reset_n(reset_n), .gap(gap), .ret_go(ret_go),
		.inst_done(inst_done), .return_from_interrupt_done(return_from_interrupt_done));
	// *********
	// tasks
	// *********
	task chk(input [15:0] got, input [15:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("ERROR %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_sys);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk_sys);
			reg_wr <= 1'b0;
		end
	endtask
	// data stand only in the cycle after the strobe
	task rd(input [7:0] a, input [7:0] exp);
		begin
			@(posedge clk_sys);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			#1;
			chk(reg_rdata_ff, exp);
		end
	endtask
	task ev(input [18:0] m);
		begin
			@(posedge clk_sys);
			src_event <= m;
			@(posedge clk_sys);
			src_event <= 19'h0_0000;
		end
	endtask
	// every cycle must stay free of calls
	task idle(input integer n);
		begin
			repeat (n) begin
				@(posedge clk_sys);
				#1;
				chk(call_req_ff, 0);
			end
		end
	endtask
	task wait_call(input [4:0] s);
		integer i;
		begin
			for (i = 0; i < 40 && call_req_ff !== 1'b1; i = i + 1) begin
				@(posedge clk_sys);
				#1;
			end
			chk(call_req_ff, 1);
			chk(call_src_ff, s);
			chk(call_vector_ff, 16'h0003 + 16'h0008 * s);
		end
	endtask
	task do_ret;
		integer i;
		begin
			@(posedge clk_sys);
			ret_go <= 1'b1;
			@(posedge clk_sys);
			ret_go <= 1'b0;
			#1;
			for (i = 0; i < 40 && return_from_interrupt_done !== 1'b1; i = i + 1) begin
				@(posedge clk_sys);
				#1;
			end
			chk(return_from_interrupt_done, 1);
			@(posedge clk_sys);
			#1;
		end
	endtask
	task stop_test;
		begin
			$display("errors %0d compares %0d", n_errors, compares);
			if (n_errors == 0 && compares > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// *********
	// clock, watchdog, tests
	// *********
	initial forever #5 clk_sys = ~clk_sys;
	// a hang counts as a failure
	initial begin
		#300000;
		n_errors = n_errors + 1;
		stop_test;
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(`ADDR_IE, 8'h00);
		rd(`ADDR_IP, 8'h00);
		rd(8'h00, 8'h00);
		ev(19'h0_0020);
		rd(`ADDR_PEND0, 8'h20);
		wr(`ADDR_IE, 8'h20);
		idle(12);
		wr(`ADDR_IE, 8'hA0);
		wait_call(5);
		rd(`ADDR_PEND0, 8'h20);
		do_ret;
		wait_call(5);
		wr(`ADDR_PEND0, 8'h00);
		do_ret;
		chk(in_service_lo_ff, 0);
		gap <= 3'h0;
		wr(`ADDR_IE, 8'h8F);
		wr(`ADDR_EIE1, 8'h04);
		wr(`ADDR_EIP1, 8'h04);
		ev(19'h0_0004);
		wait_call(2);
		rd(`ADDR_PEND0, 8'h00);
		ev(19'h0_0200);
		wait_call(9);
		chk(in_service_lo_ff, 1);
		rd(`ADDR_NEST, 8'h03);
		ev(19'h0_000A);
		idle(10);
		wr(`ADDR_PEND1, 8'h00);
		do_ret;
		chk(in_service_lo_ff, 1);
		idle(10);
		do_ret;
		wait_call(1);
		do_ret;
		wait_call(3);
		do_ret;
		ev(19'h0_0201);
		wait_call(9);
		wr(`ADDR_PEND1, 8'h00);
		do_ret;
		wait_call(0);
		do_ret;
		gap <= 3'h6;
		wr(`ADDR_EIE2, 8'h08);
		wr(`ADDR_PEND2, 8'h08);
		wait_call(18);
		wr(`ADDR_PEND2, 8'h00);
		do_ret;
		wr(`ADDR_IE, 8'h20);
		ev(19'h0_0020);
		idle(12);
		wr(`ADDR_IE, 8'hA0);
		wait_call(5);
		wr(`ADDR_PEND0, 8'h00);
		do_ret;
		rd(`ADDR_EVT_STAT, 8'h07);
		chk(irq_ff, 0);
		wr(`ADDR_EVT_MASK, 8'h02);
		idle(2);
		chk(irq_ff, 1);
		wr(`ADDR_EVT_STAT, 8'h02);
		idle(2);
		chk(irq_ff, 0);
		rd(`ADDR_EVT_STAT, 8'h05);
		rd(`ADDR_NEST, 8'h00);
		// read data must fall back to zero one cycle after they stand
		idle(1);
		chk(reg_rdata_ff, 8'h00);
		stop_test;
	end
endmodule
